// ### verilog/waveform_playback_trigger_control.v
// Trigger controller for a waveform playback engine with Wishbone registers
//
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "main_trigger_input_ctrl_consts.vh"
module waveform_playback_trigger_control #(
	parameter ADDR_W = 16,
	parameter GAP_CYC = `RETRIG_GAP_CYC
) (
	input  wire              clk,
	input  wire              rst,
	input  wire [7:0]        wb_adr_i,
	input  wire [31:0]       wb_dat_i,
	output reg  [31:0]       wb_dat_o,
	input  wire              wb_we_i,
	input  wire [3:0]        wb_sel_i,
	input  wire              wb_cyc_i,
	input  wire              wb_stb_i,
	output reg               wb_ack_o,
	input  wire              main_trigger_input,
	input  wire              segment_trigger_input,
	output reg               play_active,
	output reg               play_restart,
	output reg  [ADDR_W-1:0] sample_addr,
	output wire              run_status
);
	reg [10:0]       ctrl_reg;
	reg [6:0]        repeat_count;
	reg [15:0]       wave_len_reg;
	reg [1:0]        state_reg;
	reg [6:0]        pass_reg;
	reg [15:0]       gap_reg;
	reg              enable_last_reg;
	reg              soft_stb;
	reg              bus_stb;
	wire             main_pulse;
	wire             seg_pulse;

	localparam ST_IDLE = 2'h0;
	localparam ST_RUN  = 2'h1;
	localparam ST_DONE = 2'h2;

	wire [1:0] mode_sel    = ctrl_reg[`CTRL_MODE_HI:`CTRL_MODE_LO];
	wire [1:0] src_sel     = ctrl_reg[`CTRL_SRC_HI:`CTRL_SRC_LO];
	wire [1:0] seg_src_sel = ctrl_reg[`CTRL_SEGSRC_HI:`CTRL_SEGSRC_LO];
	wire       playback_enable = ctrl_reg[`CTRL_ENABLE];
	wire       retrigger_enable = ctrl_reg[`CTRL_RETRIG] | ctrl_reg[`CTRL_MULTISEG];
	wire       wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire       wb_wr  = wb_req & wb_we_i;

	// repeat honoured only with automatic segment source
	wire [1:0] eff_mode = (mode_sel == `MODE_REPEAT && seg_src_sel != `SRC_AUTO) ?
		`MODE_CONT : mode_sel;

	// Clamp a requested repeat count into its legal range
	function [6:0] clamp_count;
		input [6:0] v;
		begin
			if (v < `REPEAT_MIN)
				clamp_count = `REPEAT_MIN;
			else if (v > `REPEAT_MAX)
				clamp_count = `REPEAT_MAX;
			else
				clamp_count = v;
		end
	endfunction

	// Main trigger pin conditioning
	edge_sync u_main_sync (
		.clk     (clk),
		.rst     (rst),
		.pin     (main_trigger_input),
		.falling (ctrl_reg[`CTRL_MAIN_NEG]),
		.pulse   (main_pulse)
	);

	// Segment trigger pin conditioning
	edge_sync u_seg_sync (
		.clk     (clk),
		.rst     (rst),
		.pin     (segment_trigger_input),
		.falling (ctrl_reg[`CTRL_SEG_NEG]),
		.pulse   (seg_pulse)
	);

	// four selectable trigger sources
	// Trigger event from the selected source
	reg main_trigger_input_event;
	always @* begin
		case (src_sel)
			`SRC_MANUAL:   main_trigger_input_event = soft_stb;
			// segment edge only with external source
			`SRC_EXTERNAL: main_trigger_input_event = main_pulse | (seg_pulse & seg_src_sel == `SRC_EXTERNAL);
			`SRC_BUS:      main_trigger_input_event = bus_stb;
			default:       main_trigger_input_event = 1'b0;
		endcase
	end

	wire enable_rise = playback_enable & ~enable_last_reg;
	wire auto_start  = (src_sel == `SRC_AUTO) & enable_rise;
	wire gap_ok      = (gap_reg == 16'h0000);
	wire last_sample = (sample_addr == wave_len_reg[ADDR_W-1:0] - {{(ADDR_W-1){1'b0}}, 1'b1});

	// Register writes and command strobes
	always @(posedge clk) begin
		if (rst) begin
			ctrl_reg     <= `CTRL_RESET;
			repeat_count <= `REPEAT_RESET;
			wave_len_reg <= `WAVE_LEN_RESET;
			soft_stb     <= 1'b0;
			bus_stb      <= 1'b0;
		end else begin
			soft_stb <= 1'b0;
			bus_stb  <= 1'b0;
			if (wb_wr && wb_adr_i == `REG_CTRL) begin
				if (wb_sel_i[0])
					ctrl_reg[7:0] <= wb_dat_i[7:0];
				if (wb_sel_i[1])
					ctrl_reg[10:8] <= wb_dat_i[10:8];
			end
			if (wb_wr && wb_adr_i == `REG_REPEAT && wb_sel_i[0])
				repeat_count <= clamp_count(wb_dat_i[6:0]);
			if (wb_wr && wb_adr_i == `REG_STROBE && wb_sel_i[0]) begin
				soft_stb <= wb_dat_i[`STB_SOFT];
				bus_stb  <= wb_dat_i[`STB_BUS];
			end
			if (wb_wr && wb_adr_i == `REG_WAVE_LEN) begin
				if (wb_sel_i[0])
					wave_len_reg[7:0] <= wb_dat_i[7:0];
				if (wb_sel_i[1])
					wave_len_reg[15:8] <= wb_dat_i[15:8];
			end
		end
	end

	// Bus read data and single-cycle acknowledge
	always @(posedge clk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i) begin
				case (wb_adr_i)
					`REG_CTRL:     wb_dat_o <= {21'h000000, ctrl_reg};
					`REG_REPEAT:   wb_dat_o <= {25'h0000000, repeat_count};
					`REG_STATUS:   wb_dat_o <= {23'h000000, pass_reg, state_reg};
					`REG_WAVE_LEN: wb_dat_o <= {16'h0000, wave_len_reg};
					default:       wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end

	assign run_status = (state_reg == ST_RUN);

	// Playback sequencer
	always @(posedge clk) begin
		if (rst) begin
			state_reg       <= ST_IDLE;
			pass_reg        <= 7'h00;
			gap_reg         <= 16'h0000;
			sample_addr     <= {ADDR_W{1'b0}};
			play_active     <= 1'b0;
			play_restart    <= 1'b0;
			enable_last_reg <= 1'b0;
		end else begin
			enable_last_reg <= playback_enable;
			play_restart    <= 1'b0;
			if (gap_reg != 16'h0000)
				gap_reg <= gap_reg - 16'h0001;
			if (!playback_enable) begin
				state_reg   <= ST_IDLE;
				play_active <= 1'b0;
				sample_addr <= {ADDR_W{1'b0}};
			end else begin
				case (state_reg)
					ST_IDLE, ST_DONE: begin
						// finished run restarts on trigger, or on enable rise with automatic source
						if (main_trigger_input_event || auto_start) begin
							state_reg    <= ST_RUN;
							pass_reg     <= 7'h00;
							sample_addr  <= {ADDR_W{1'b0}};
							play_active  <= 1'b1;
							play_restart <= 1'b1;
							gap_reg      <= GAP_CYC[15:0];
						end
					end
					ST_RUN: begin
						if (main_trigger_input_event && retrigger_enable && gap_ok) begin
							pass_reg     <= 7'h00;
							sample_addr  <= {ADDR_W{1'b0}};
							play_restart <= 1'b1;
							gap_reg      <= GAP_CYC[15:0];
						end else if (last_sample) begin
							sample_addr <= {ADDR_W{1'b0}};
							case (eff_mode)
								`MODE_SINGLE: begin
									state_reg   <= ST_DONE;
									play_active <= 1'b0;
								end
								`MODE_REPEAT: begin
									if (pass_reg + 7'h01 >= repeat_count) begin
										state_reg   <= ST_DONE;
										play_active <= 1'b0;
									end else begin
										pass_reg <= pass_reg + 7'h01;
									end
								end
								default: pass_reg <= pass_reg;
							endcase
						end else begin
							sample_addr <= sample_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
						end
					end
					default: state_reg <= ST_IDLE;
				endcase
			end
		end
	end
endmodule

// ### verilog/main_trigger_input_ctrl_consts.vh
// Constants for the waveform playback trigger controller
`ifndef MAIN_TRIGGER_INPUT_CTRL_CONSTS_VH
`define MAIN_TRIGGER_INPUT_CTRL_CONSTS_VH

// Register byte offsets
`define REG_CTRL        8'h00
`define REG_REPEAT      8'h04
`define REG_STROBE      8'h08
`define REG_STATUS      8'h0c
`define REG_WAVE_LEN    8'h10

// Control register fields
`define CTRL_MODE_LO    0
`define CTRL_MODE_HI    1
`define CTRL_RETRIG     2
`define CTRL_SRC_LO     3
`define CTRL_SRC_HI     4
`define CTRL_SEGSRC_LO  5
`define CTRL_SEGSRC_HI  6
`define CTRL_MAIN_NEG   7
`define CTRL_SEG_NEG    8
`define CTRL_ENABLE     9
`define CTRL_MULTISEG   10

// Strobe register fields
`define STB_SOFT        0
`define STB_BUS         1

// Playback modes
`define MODE_CONT       2'h0
`define MODE_SINGLE     2'h1
`define MODE_REPEAT     2'h2

// Trigger sources
`define SRC_MANUAL      2'h0
`define SRC_EXTERNAL    2'h1
`define SRC_BUS         2'h2
`define SRC_AUTO        2'h3

// Reset values and repeat count limits
`define CTRL_RESET      11'h01c
`define REPEAT_RESET    7'h01
`define REPEAT_MIN      7'h01
`define REPEAT_MAX      7'h64
`define WAVE_LEN_RESET  16'h0040

// Retrigger spacing: 10 us plus 25 sample periods at 200 MHz
`define CLK_MHZ         200
`define RETRIG_GAP_US   10
`define RETRIG_GAP_SMP  25
`define RETRIG_GAP_CYC  (`RETRIG_GAP_US * `CLK_MHZ + `RETRIG_GAP_SMP)

`endif

// ### verilog/edge_sync.v
// Two-stage synchroniser with selectable active edge detector
`timescale 1ns/1ps
module edge_sync (
	input  wire clk,
	input  wire rst,
	input  wire pin,
	input  wire falling,
	output reg  pulse
);
	reg meta_reg;
	reg sync_reg;
	reg last_reg;

	always @(posedge clk) begin
		if (rst) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			last_reg <= 1'b0;
			pulse    <= 1'b0;
		end else begin
			meta_reg <= pin;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
			pulse    <= falling ? (last_reg & ~sync_reg) : (sync_reg & ~last_reg);
		end
	end
endmodule

// ### verification/main_trigger_input_source.sv
// Model of the external trigger source driving both trigger pins
`timescale 1ns/1ps
module main_trigger_input_source (
	input  wire clk,
	input  wire fire_main,
	input  wire fire_seg,
	output reg  main_pin,
	output reg  seg_pin
);
	initial main_pin = 1'b0;
	initial seg_pin = 1'b0;
	// Each request flips a pin, so edges alternate rising and falling
	always @(posedge clk) begin
		if (fire_main)
			main_pin <= ~main_pin;
		if (fire_seg)
			seg_pin <= ~seg_pin;
	end
endmodule

// ### verification/main_trigger_input_ctrl_chk.sv
// Concurrent checks on the trigger controller ports
`timescale 1ns/1ps
module main_trigger_input_ctrl_chk #(
	parameter ADDR_W  = 16,
	parameter GAP_CYC = 2025
) (
	input wire              clk,
	input wire              rst,
	input wire [7:0]        wb_adr_i,
	input wire [31:0]       wb_dat_i,
	input wire [31:0]       wb_dat_o,
	input wire              wb_we_i,
	input wire [3:0]        wb_sel_i,
	input wire              wb_cyc_i,
	input wire              wb_stb_i,
	input wire              wb_ack_o,
	input wire              main_trigger_input,
	input wire              segment_trigger_input,
	input wire              play_active,
	input wire              play_restart,
	input wire [ADDR_W-1:0] sample_addr,
	input wire              run_status
);
	reg [15:0] gap_reg;
	// Cycles since the last restart, saturating
	always @(posedge clk) begin
		if (rst)
			gap_reg <= 16'hffff;
		else if (play_restart)
			gap_reg <= 16'h0000;
		else if (gap_reg != 16'hffff)
			gap_reg <= gap_reg + 16'h0001;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ack;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	property p_ack;
		s_req |=> s_ack;
	endproperty
	a_ack: assert property (p_ack) else $error("ack missing or too long");
	property p_ack_cause;
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_unmapped;
		wb_ack_o && !wb_we_i && wb_adr_i >= 8'h14 |-> wb_dat_o == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_rst;
		disable iff (1'b0) rst |=> !wb_ack_o && !play_active && !run_status && sample_addr == 0;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
	property p_restart_zero;
		play_restart |-> sample_addr == 0 && run_status;
	endproperty
	a_restart_zero: assert property (p_restart_zero) else $error("restart not at zero");
	property p_start;
		$rose(run_status) |-> play_restart;
	endproperty
	a_start: assert property (p_start) else $error("run without restart");
	property p_pulse;
		play_restart |=> !play_restart;
	endproperty
	a_pulse: assert property (p_pulse) else $error("restart pulse too long");
	property p_gap;
		play_restart |-> gap_reg >= GAP_CYC - 1;
	endproperty
	a_gap: assert property (p_gap) else $error("restarts too close");
	property p_addr_step;
		play_active && $past(play_active) && !play_restart && sample_addr != 0
			|-> sample_addr == $past(sample_addr) + 1'b1;
	endproperty
	a_addr_step: assert property (p_addr_step) else $error("address skipped");
endmodule
bind waveform_playback_trigger_control main_trigger_input_ctrl_chk #(.ADDR_W(ADDR_W), .GAP_CYC(GAP_CYC)) chk_u (
	.clk(clk), .rst(rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .main_trigger_input(main_trigger_input),
	.segment_trigger_input(segment_trigger_input), .play_active(play_active),
	.play_restart(play_restart), .sample_addr(sample_addr), .run_status(run_status));

// ### verification/tb.sv
// Self-checking bench for the playback trigger controller
`timescale 1ns/1ps
`include "main_trigger_input_ctrl_consts.vh"
module tb;
	reg         clk = 1'b0;
	reg         rst = 1'b1;
	reg  [7:0]  adr = 8'h00;
	reg  [31:0] wdat = 32'h0;
	reg         we = 1'b0;
	reg         stb = 1'b0;
	reg         fm = 1'b0;
	reg         fs = 1'b0;
	reg  [31:0] q;
	wire [31:0] rdat;
	wire        ack, mpin, spin, act, rsta, run;
	wire [15:0] addr;
	integer     error_cnt = 0;
	integer     cmp_count = 0;
	integer     cyc_n = 0;
	integer     rcnt = 0;
	integer     acnt = 0;
	integer     r0, a0;
	always #2.5 clk = ~clk;
	waveform_playback_trigger_control #(.GAP_CYC(8)) dut_u (.clk(clk), .rst(rst),
		.wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(4'hf),
		.wb_cyc_i(stb), .wb_stb_i(stb), .wb_ack_o(ack), .main_trigger_input(mpin),
		.segment_trigger_input(spin), .play_active(act), .play_restart(rsta),
		.sample_addr(addr), .run_status(run));
	main_trigger_input_source src_u (.clk(clk), .fire_main(fm), .fire_seg(fs), .main_pin(mpin),
		.seg_pin(spin));
	task end_of_test;
		begin
			$display("errors=%0d compares=%0d", error_cnt, cmp_count);
			if (error_cnt == 0 && cmp_count > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	// Counts restarts and active cycles, cuts a hang short
	always @(posedge clk) begin
		cyc_n <= cyc_n + 1;
		rcnt <= rcnt + (rsta === 1'b1);
		acnt <= acnt + (act === 1'b1);
		if (cyc_n > 5000) begin
			error_cnt = error_cnt + 1;
			end_of_test;
		end
	end
	task wt(input integer n);
		repeat (n) @(posedge clk);
	endtask
	// Classic single cycle, held until ack is sampled
	task wb(input [7:0] a, input w, input [31:0] d);
		begin
			adr <= a;
			we <= w;
			wdat <= d;
			stb <= 1'b1;
			@(posedge clk);
			while (ack !== 1'b1) @(posedge clk);
			q = rdat;
			stb <= 1'b0;
			@(posedge clk);
		end
	endtask
	task chk(input [31:0] g, input [31:0] e);
		begin
			cmp_count = cmp_count + 1;
			if (g !== e) begin
				error_cnt = error_cnt + 1;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
			end
		end
	endtask
	// Strobe or pin edge, then count restarts after the spacing
	task st(input [31:0] v, input ext, input integer d);
		begin
			r0 = rcnt;
			if (ext) fm <= 1'b1;
			else wb(`REG_STROBE, 1'b1, v);
			wt(1);
			fm <= 1'b0;
			wt(14);
			chk(rcnt - r0, d);
		end
	endtask
	initial begin
		wt(2);
		rst <= 1'b0;
		wt(1);
		wb(`REG_CTRL, 0, 0);
		chk(q, 32'h01c);
		wb(`REG_REPEAT, 0, 0);
		chk(q, 32'h1);
		wb(8'h20, 0, 0);
		chk(q, 32'h0);
		wb(`REG_REPEAT, 1, 0);
		wb(`REG_REPEAT, 0, 0);
		chk(q, 32'h1);
		wb(`REG_REPEAT, 1, 32'h65);
		wb(`REG_REPEAT, 0, 0);
		chk(q, 32'h64);
		wb(`REG_WAVE_LEN, 1, 4);
		wb(`REG_WAVE_LEN, 0, 0);
		chk(q, 32'h4);
		r0 = rcnt;
		wb(`REG_CTRL, 1, 32'h21c);
		wt(20);
		chk({act, run, rcnt[3:0] - r0[3:0]}, 6'h31);
		wb(`REG_CTRL, 1, 32'h01c);
		wb(`REG_CTRL, 1, 32'h21c);
		wt(4);
		chk(rcnt - r0, 2);
		wb(`REG_CTRL, 1, 32'h0);
		wb(`REG_CTRL, 1, 32'h200);
		wt(4);
		chk(run, 0);
		st(2, 0, 0);
		st(1, 0, 1);
		st(1, 0, 0);
		wb(`REG_CTRL, 1, 32'h204);
		r0 = rcnt;
		wb(`REG_STROBE, 1, 1);
		wb(`REG_STROBE, 1, 1);
		wt(14);
		chk(rcnt - r0, 1);
		st(1, 0, 1);
		wb(`REG_CTRL, 1, 32'h0);
		wb(`REG_CTRL, 1, 32'h600);
		st(1, 0, 1);
		st(1, 0, 1);
		wb(`REG_CTRL, 1, 32'h0);
		wb(`REG_CTRL, 1, 32'h211);
		st(1, 0, 0);
		st(2, 0, 1);
		chk({act, run}, 0);
		wb(`REG_STATUS, 0, 0);
		chk(q, 32'h2);
		st(2, 0, 1);
		wb(`REG_CTRL, 1, 32'h229);
		st(0, 1, 1);
		st(0, 1, 0);
		wb(`REG_CTRL, 1, 32'h2a9);
		st(0, 1, 0);
		st(0, 1, 1);
		r0 = rcnt;
		fs <= 1'b1;
		wt(1);
		fs <= 1'b0;
		wt(14);
		chk(rcnt - r0, 1);
		wb(`REG_CTRL, 1, 32'h0);
		wb(`REG_REPEAT, 1, 3);
		a0 = acnt;
		wb(`REG_CTRL, 1, 32'h27a);
		wt(30);
		chk(acnt - a0, 12);
		chk(run, 0);
		r0 = rcnt;
		wb(`REG_CTRL, 1, 32'h07a);
		wb(`REG_CTRL, 1, 32'h27a);
		wt(4);
		chk(rcnt - r0, 1);
		wb(`REG_CTRL, 1, 32'h0);
		wb(`REG_CTRL, 1, 32'h21a);
		wt(40);
		chk(act, 1);
		end_of_test;
	end
endmodule
